// >>> rtl/gesture_detect_control.sv
// gesture control registers, crosstalk correction and integration sequencer
// Behaviour
// - wait 0,2,4,6,10,14,18,22 ms between datasets, from bits 6:4
// - fire led pulse count from bits 3:0; zero still gives one pulse
// - leave integration on exit occurrence number persistence field plus one
// - compare proximity result with entry threshold to start integration
// - entry threshold zero enters on any valid proximity result while gesture mode is enabled
// - entry threshold low 8 bits at 0x93, high 3 at 0xc3, reset ones
// - compare gesture data with exit threshold at 0x94 to leave
// - exit threshold zero runs a full 32 datasets before leaving
// - exit or gate threshold all ones blocks every gesture event
// - event only when west-east or north-south difference exceeds gate, or gate is zero
// - gate threshold zero triggers an event unless exit threshold is all ones
// - subtract north, south, east, west offsets at 0x96 to 0x99
// - read-only part code in bits 7:4, bits 3:0 reserved
// - read-only maker code at 0x9b
`timescale 1ns/1ns
`default_nettype none
`include "gesture_consts.svh"
module gesture_detect_control
#(
    parameter int unsigned CYCLES_PER_MS = `NS_PER_MS / `CLK_PERIOD_NS,
    // arbitrary identity values
    parameter logic [3:0]  DEVICE_CODE   = 4'h3,
    parameter logic [7:0]  MAKER_CODE    = 8'h5a
)
(
    // clock and reset
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_reset_n,
    // register port
    input  wire logic [7:0]              i_reg_addr,
    input  wire logic [7:0]              i_reg_wdata,
    input  wire logic                    i_reg_wr,
    input  wire logic                    i_reg_rd,
    output logic      [7:0]              o_reg_rdata,
    output logic                         o_reg_rvalid,
    // measurement side
    input  wire logic                    i_gesture_mode_enable,
    input  wire gesture_pkg::prox_data_t i_proximity_result,
    input  wire logic                    i_proximity_valid,
    input  wire gesture_pkg::dir_data_t  i_north_raw,
    input  wire gesture_pkg::dir_data_t  i_south_raw,
    input  wire gesture_pkg::dir_data_t  i_east_raw,
    input  wire gesture_pkg::dir_data_t  i_west_raw,
    input  wire logic                    i_dataset_valid,
    // sequencer outputs
    output logic                         o_gesture_led,
    output logic                         o_dataset_req,
    output logic                         o_gesture_event,
    output logic                         o_integrating,
    output gesture_pkg::dir_data_t       o_north_data,
    output gesture_pkg::dir_data_t       o_south_data,
    output gesture_pkg::dir_data_t       o_east_data,
    output gesture_pkg::dir_data_t       o_west_data
);
    import gesture_pkg::*;

    function automatic wait_count_t wait_cycles(input logic [2:0] code);
        int unsigned ms;
        ms = `WAIT_MS_0;
        unique case (code)
            3'h0: ms = `WAIT_MS_0;
            3'h1: ms = `WAIT_MS_1;
            3'h2: ms = `WAIT_MS_2;
            3'h3: ms = `WAIT_MS_3;
            3'h4: ms = `WAIT_MS_4;
            3'h5: ms = `WAIT_MS_5;
            3'h6: ms = `WAIT_MS_6;
            3'h7: ms = `WAIT_MS_7;
        endcase
        wait_cycles = wait_count_t'(ms * CYCLES_PER_MS);
    endfunction

    function automatic dir_data_t abs_diff(input dir_data_t a,
                                           input dir_data_t b);
        abs_diff = (a > b) ? dir_data_t'(a - b) : dir_data_t'(b - a);
    endfunction

    // registers
    logic [6:0]  wait_pulse_reg;
    logic [1:0]  persist_reg;
    prox_data_t  entry_reg;
    dir_data_t   exit_reg, gate_reg;
    dir_data_t   xn_reg, xs_reg, xe_reg, xw_reg;

    // sequencer state
    seq_state_t  state_reg, state_next;
    logic        led_reg;
    logic [3:0]  pulse_cnt_reg;
    wait_count_t wait_cnt_reg;
    logic [5:0]  ds_cnt_reg;
    logic [1:0]  occ_cnt_reg;
    logic        gated_reg;
    logic        req_reg, event_reg;
    dir_data_t   on_reg, os_reg, oe_reg, ow_reg;
    logic [7:0]  rdata_reg;
    logic        rvalid_reg;

    // write decode
    wire wr_wait  = i_reg_wr && (i_reg_addr == `ADDR_WAIT_PULSE);
    wire wr_pers  = i_reg_wr && (i_reg_addr == `ADDR_EXIT_PERSIST);
    wire wr_entl  = i_reg_wr && (i_reg_addr == `ADDR_ENTRY_LOW);
    wire wr_enth  = i_reg_wr && (i_reg_addr == `ADDR_ENTRY_HIGH);
    wire wr_exit  = i_reg_wr && (i_reg_addr == `ADDR_EXIT_THR);
    wire wr_gate  = i_reg_wr && (i_reg_addr == `ADDR_GATE_THR);
    wire wr_xn    = i_reg_wr && (i_reg_addr == `ADDR_XTALK_N);
    wire wr_xs    = i_reg_wr && (i_reg_addr == `ADDR_XTALK_S);
    wire wr_xe    = i_reg_wr && (i_reg_addr == `ADDR_XTALK_E);
    wire wr_xw    = i_reg_wr && (i_reg_addr == `ADDR_XTALK_W);

    xtalk_if xt ();
    assign xt.raw_n = i_north_raw;
    assign xt.raw_s = i_south_raw;
    assign xt.raw_e = i_east_raw;
    assign xt.raw_w = i_west_raw;
    assign xt.off_n = xn_reg;
    assign xt.off_s = xs_reg;
    assign xt.off_e = xe_reg;
    assign xt.off_w = xw_reg;
    crosstalk_sub u_xtalk (.x(xt.sub));

    // field selection
    wire [2:0] wait_code   = wait_pulse_reg[`WAIT_FIELD_MSB:`WAIT_FIELD_LSB];
    wire [3:0] pulse_field = wait_pulse_reg[`PULSE_FIELD_MSB:`PULSE_FIELD_LSB];
    wire [3:0] last_idx    = (pulse_field == 4'h0) ? 4'h0
                                                   : 4'(pulse_field - 4'h1);
    wire       last_pulse  = led_reg && (pulse_cnt_reg == last_idx);

    wire entry_ok = i_gesture_mode_enable && i_proximity_valid &&
                    ((entry_reg == 11'h000) ||
                     (i_proximity_result > entry_reg));
    wire blocked  = (exit_reg == `THR_BLOCK) || (gate_reg == `THR_BLOCK);
    wire dwe_big  = abs_diff(xt.corr_w, xt.corr_e) > gate_reg;
    wire dns_big  = abs_diff(xt.corr_n, xt.corr_s) > gate_reg;
    wire gate_ok  = !blocked &&
                    ((gate_reg == 8'h00) || dwe_big || dns_big);
    // every direction below exit threshold is an exit occurrence
    wire exit_hit = (exit_reg != 8'h00) &&
                    (xt.corr_n < exit_reg) && (xt.corr_s < exit_reg) &&
                    (xt.corr_e < exit_reg) && (xt.corr_w < exit_reg);
    // leave on occurrence persistence plus one
    // at most a full run of datasets
    wire full_run = ds_cnt_reg == 6'(`FULL_RUN_DATASETS - 6'h01);
    wire leave    = full_run || (exit_hit && (occ_cnt_reg == persist_reg));
    wire sample   = (state_reg == ST_SAMPLE) && i_dataset_valid;
    wire go_on    = gated_reg ? !leave : gate_ok;
    wire gate_now = sample && !gated_reg && gate_ok;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:   if (entry_ok) state_next = ST_PULSE;
            ST_PULSE:  if (last_pulse) state_next = ST_SAMPLE;
            ST_SAMPLE: if (i_dataset_valid)
                           state_next = go_on ? ST_WAIT : ST_IDLE;
            ST_WAIT:   if (wait_cnt_reg == 22'h00_0000)
                           state_next = ST_PULSE;
        endcase
        if (!i_gesture_mode_enable)
            state_next = ST_IDLE;
    end

    // read mux; reserved bits read zero, except device id bits 3:0, which read 1
    logic [7:0] rdata_next;
    always_comb
    begin
        rdata_next = 8'h00;
        unique case (i_reg_addr)
            `ADDR_WAIT_PULSE:   rdata_next = {1'b0, wait_pulse_reg};
            `ADDR_EXIT_PERSIST: rdata_next = {4'h0, persist_reg, 2'b00};
            `ADDR_ENTRY_LOW:    rdata_next = entry_reg[7:0];
            `ADDR_ENTRY_HIGH:   rdata_next = {5'h00, entry_reg[10:8]};
            `ADDR_EXIT_THR:     rdata_next = exit_reg;
            `ADDR_GATE_THR:     rdata_next = gate_reg;
            `ADDR_XTALK_N:      rdata_next = xn_reg;
            `ADDR_XTALK_S:      rdata_next = xs_reg;
            `ADDR_XTALK_E:      rdata_next = xe_reg;
            `ADDR_XTALK_W:      rdata_next = xw_reg;
            `ADDR_DEVICE_ID:    rdata_next = {DEVICE_CODE, `ID_RESERVED_BITS};
            `ADDR_MAKER_ID:     rdata_next = MAKER_CODE;
            default:            rdata_next = 8'h00;
        endcase
    end

    // entry threshold split over two offsets, reset to ones
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            entry_reg <= `RST_ENTRY;
        else
        begin
            if (wr_entl) entry_reg[7:0]  <= i_reg_wdata;
            if (wr_enth) entry_reg[10:8] <= i_reg_wdata[2:0];
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            wait_pulse_reg <= `RST_WAIT_PULSE;
            persist_reg    <= `RST_PERSIST;
            exit_reg       <= `RST_EXIT;
            gate_reg       <= `RST_GATE;
        end
        else
        begin
            if (wr_wait) wait_pulse_reg <= i_reg_wdata[6:0];
            if (wr_pers)
                persist_reg <= i_reg_wdata[`PERSIST_FIELD_MSB:
                                           `PERSIST_FIELD_LSB];
            if (wr_exit) exit_reg <= i_reg_wdata;
            if (wr_gate) gate_reg <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            xn_reg <= `RST_XTALK;
            xs_reg <= `RST_XTALK;
            xe_reg <= `RST_XTALK;
            xw_reg <= `RST_XTALK;
        end
        else
        begin
            if (wr_xn) xn_reg <= i_reg_wdata;
            if (wr_xs) xs_reg <= i_reg_wdata;
            if (wr_xe) xe_reg <= i_reg_wdata;
            if (wr_xw) xw_reg <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= i_reg_rd;
            if (i_reg_rd) rdata_reg <= rdata_next;
        end
    end

    // led toggles, one count per completed pulse
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || state_next != ST_PULSE)
        begin
            led_reg       <= 1'b0;
            pulse_cnt_reg <= 4'h0;
        end
        else
        begin
            led_reg <= !led_reg;
            if (led_reg) pulse_cnt_reg <= 4'(pulse_cnt_reg + 4'h1);
        end
    end

    // wait loaded on entry, counted down
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            wait_cnt_reg <= 22'h00_0000;
        else if (state_reg != ST_WAIT)
            wait_cnt_reg <= wait_cycles(wait_code);
        else if (wait_cnt_reg != 22'h00_0000)
            wait_cnt_reg <= 22'(wait_cnt_reg - 22'h00_0001);
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || state_next == ST_IDLE)
        begin
            gated_reg   <= 1'b0;
            ds_cnt_reg  <= 6'h00;
            occ_cnt_reg <= 2'h0;
        end
        else if (gate_now)
        begin
            gated_reg  <= 1'b1;
            ds_cnt_reg <= 6'h01;
        end
        else if (sample && gated_reg)
        begin
            ds_cnt_reg <= 6'(ds_cnt_reg + 6'h01);
            if (exit_hit) occ_cnt_reg <= 2'(occ_cnt_reg + 2'h1);
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            state_reg <= ST_IDLE;
            req_reg   <= 1'b0;
            event_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            req_reg   <= (state_reg == ST_PULSE) && (state_next == ST_SAMPLE);
            event_reg <= gate_now && i_gesture_mode_enable;
        end
    end

    // corrected data captured per dataset
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            on_reg <= 8'h00;
            os_reg <= 8'h00;
            oe_reg <= 8'h00;
            ow_reg <= 8'h00;
        end
        else if (sample)
        begin
            on_reg <= xt.corr_n;
            os_reg <= xt.corr_s;
            oe_reg <= xt.corr_e;
            ow_reg <= xt.corr_w;
        end
    end

    assign o_reg_rdata     = rdata_reg;
    assign o_reg_rvalid    = rvalid_reg;
    assign o_gesture_led   = led_reg;
    assign o_dataset_req   = req_reg;
    assign o_gesture_event = event_reg;
    assign o_integrating   = gated_reg;
    assign o_north_data    = on_reg;
    assign o_south_data    = os_reg;
    assign o_east_data     = oe_reg;
    assign o_west_data     = ow_reg;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    a_wait_load_len: assert property (
        $rose(state_reg == ST_WAIT) |->
        wait_cnt_reg == wait_cycles($past(wait_code)))
    else $error("wait length does not match wait code");

    a_led_pulse_count: assert property (
        (state_reg == ST_PULSE && state_next == ST_SAMPLE) |->
        led_reg && pulse_cnt_reg == last_idx)
    else $error("led pulse count wrong");

    a_persist_exit: assert property (
        (sample && gated_reg && exit_hit && i_gesture_mode_enable &&
         occ_cnt_reg == persist_reg) |=> state_reg == ST_IDLE)
    else $error("exit persistence not honoured");

    a_entry_refuse: assert property (
        (state_reg == ST_IDLE && entry_reg != 11'h000 &&
         i_proximity_result <= entry_reg) |=> state_reg == ST_IDLE)
    else $error("entered below entry threshold");

    a_entry_zero: assert property (
        (state_reg == ST_IDLE && entry_reg == 11'h000 &&
         i_gesture_mode_enable && i_proximity_valid)
        |=> state_reg == ST_PULSE && o_gesture_led)
    else $error("zero entry threshold did not enter");

    a_entry_reset: assert property (
        disable iff (1'b0)
        !i_reset_n |=> entry_reg == `RST_ENTRY)
    else $error("entry threshold reset value wrong");

    a_full_run: assert property (
        (sample && gated_reg && exit_reg == 8'h00 &&
         i_gesture_mode_enable && !full_run)
        |=> state_reg == ST_WAIT && o_integrating)
    else $error("left before full run");

    a_block_ones: assert property (
        o_gesture_event |-> $past(!blocked))
    else $error("event with blocking threshold");

    a_gate_zero: assert property (
        (sample && !gated_reg && gate_reg == 8'h00 &&
         exit_reg != `THR_BLOCK && i_gesture_mode_enable)
        |=> o_gesture_event ##1 !o_gesture_event)
    else $error("zero gate did not trigger");

    a_gate_needed: assert property (
        o_gesture_event |-> $past(gate_reg == 8'h00 || dwe_big || dns_big))
    else $error("event without directional difference");

    a_xtalk_sat: assert property (
        sample |=> o_north_data <= $past(i_north_raw) &&
                   o_west_data <= $past(i_west_raw))
    else $error("crosstalk subtraction wrapped");

    a_xtalk_exact: assert property (
        (xt.raw_n > xt.off_n) |-> 8'(xt.corr_n + xt.off_n) == xt.raw_n)
    else $error("north offset not subtracted");

    a_xtalk_clamp: assert property (
        (xt.raw_s <= xt.off_s) |-> xt.corr_s == 8'h00)
    else $error("south subtraction did not clamp");

    a_id_read: assert property (
        (i_reg_rd && i_reg_addr == `ADDR_DEVICE_ID) |=>
        o_reg_rvalid && o_reg_rdata[7:4] == DEVICE_CODE)
    else $error("part code read wrong");

    c_gesture_event: cover property (o_gesture_event);
    c_persist_leave: cover property (
        sample && gated_reg && exit_hit && persist_reg == 2'h3 && leave);
    c_full_run:      cover property (sample && full_run && gated_reg);
    c_long_wait:     cover property ($rose(state_reg == ST_WAIT) &&
                                     wait_code == 3'h7);
endmodule
`default_nettype wire

// >>> rtl/gesture_consts.svh
// register offsets, field positions, reset values and timing figures
`ifndef GESTURE_CONSTS_SVH
`define GESTURE_CONSTS_SVH

`define ADDR_WAIT_PULSE     8'h91
`define ADDR_EXIT_PERSIST   8'h92
`define ADDR_ENTRY_LOW      8'h93
`define ADDR_EXIT_THR       8'h94
`define ADDR_GATE_THR       8'h95
`define ADDR_XTALK_N        8'h96
`define ADDR_XTALK_S        8'h97
`define ADDR_XTALK_E        8'h98
`define ADDR_XTALK_W        8'h99
`define ADDR_DEVICE_ID      8'h9a
`define ADDR_MAKER_ID       8'h9b
`define ADDR_ENTRY_HIGH     8'hc3

`define WAIT_FIELD_MSB      6
`define WAIT_FIELD_LSB      4
`define PULSE_FIELD_MSB     3
`define PULSE_FIELD_LSB     0
`define PERSIST_FIELD_MSB   3
`define PERSIST_FIELD_LSB   2
`define ID_FIELD_MSB        7
`define ID_FIELD_LSB        4

`define RST_WAIT_PULSE      7'h00
`define RST_PERSIST         2'h0
`define RST_ENTRY           11'h7ff
`define RST_EXIT            8'h00
`define RST_GATE            8'h00
`define RST_XTALK           8'h00
`define ID_RESERVED_BITS    4'h1

`define THR_BLOCK           8'hff
`define FULL_RUN_DATASETS   6'h20

`define CLK_PERIOD_NS       10
`define NS_PER_MS           1000000
`define WAIT_MS_0           0
`define WAIT_MS_1           2
`define WAIT_MS_2           4
`define WAIT_MS_3           6
`define WAIT_MS_4           10
`define WAIT_MS_5           14
`define WAIT_MS_6           18
`define WAIT_MS_7           22

`endif

// >>> rtl/gesture_pkg.sv
// types shared by the gesture control block
package gesture_pkg;
    typedef logic [7:0]  dir_data_t;
    typedef logic [10:0] prox_data_t;
    typedef logic [21:0] wait_count_t;
    // gray order along idle -> pulse -> sample -> wait
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_PULSE  = 2'b01,
        ST_SAMPLE = 2'b11,
        ST_WAIT   = 2'b10
    } seq_state_t;
endpackage

// >>> rtl/xtalk_if.sv
// raw, offset and corrected directional data between top and subtractor
`timescale 1ns/1ns
`default_nettype none
interface xtalk_if;
    import gesture_pkg::*;
    dir_data_t raw_n, raw_s, raw_e, raw_w;
    dir_data_t off_n, off_s, off_e, off_w;
    dir_data_t corr_n, corr_s, corr_e, corr_w;
    modport sub (
        input  raw_n, raw_s, raw_e, raw_w,
        input  off_n, off_s, off_e, off_w,
        output corr_n, corr_s, corr_e, corr_w
    );
    modport top (
        output raw_n, raw_s, raw_e, raw_w,
        output off_n, off_s, off_e, off_w,
        input  corr_n, corr_s, corr_e, corr_w
    );
endinterface
`default_nettype wire

// >>> rtl/crosstalk_sub.sv
// per-direction crosstalk subtraction, saturating at zero
`timescale 1ns/1ns
`default_nettype none
module crosstalk_sub
(
    xtalk_if.sub x
);
    import gesture_pkg::*;

    function automatic dir_data_t sat_sub(input dir_data_t a,
                                          input dir_data_t b);
        sat_sub = (a > b) ? dir_data_t'(a - b) : 8'h00;
    endfunction

    assign x.corr_n = sat_sub(x.raw_n, x.off_n);
    assign x.corr_s = sat_sub(x.raw_s, x.off_s);
    assign x.corr_e = sat_sub(x.raw_e, x.off_e);
    assign x.corr_w = sat_sub(x.raw_w, x.off_w);
endmodule
`default_nettype wire

// >>> bench/fe_model.sv
// front-end model: answers each dataset request after a set delay
`timescale 1ns/1ns
`default_nettype none
module fe_model
(
    // clock and requests
    input  wire logic        i_clk,
    input  wire logic        i_req,
    input  wire logic        i_integ,
    // delay and the raw sets for gate and later datasets
    input  wire logic [3:0]  i_dly,
    input  wire logic [31:0] i_gate_set,
    input  wire logic [31:0] i_run_set,
    // answer
    output logic             o_valid,
    output logic [31:0]      o_raw
);
    logic [31:0] hold = 32'h0000_0000;
    int          cnt  = -1;
    // lines not held outside the valid cycle
    assign o_raw = o_valid ? hold : ~hold;
    initial o_valid = 1'b0;
    always @(posedge i_clk)
    begin
        o_valid <= (cnt == 0);
        if (i_req)
        begin
            cnt  <= i_dly;
            hold <= i_integ ? i_run_set : i_gate_set;
        end
        else if (cnt >= 0)
            cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the gesture control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import gesture_pkg::*;
    localparam int CPM = 10;
    // arbitrary identity values
    localparam logic [3:0] DEV = 4'h6;
    localparam logic [7:0] MAK = 8'h3c;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        mode = 1'b1, pv = 1'b0, dv, rvalid, led, req, ev, integ;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [3:0]  dly = 4'h0;
    logic [31:0] gset = 32'h0000_0000, rset = 32'h0000_0000, raw;
    prox_data_t  prox = 11'h000;
    dir_data_t   nd, sd, ed, wd;
    int          led_cnt = 0, req_cnt = 0, ev_cnt = 0, quiet = 0, cyc = 0;
    int          t1 = 0, t2 = 0, leds, error_cnt = 0, total_checks = 0;
    int          ei_cnt = 0;
    // address, write value, reset readback, readback after write
    logic [31:0] rows [13] = '{32'h91ff_007f, 32'h92ff_000c, 32'h9312_ff12,
        32'hc3ff_0707, 32'h9434_0034, 32'h9556_0056, 32'h96a1_00a1,
        32'h97a2_00a2, 32'h98a3_00a3, 32'h99a4_00a4, 32'h9aff_6161,
        32'h9b00_3c3c, 32'h8077_0000};
    // gate, exit, gate dataset raw values
    logic [47:0] gx [3] = '{48'h2050_3080_4060, 48'hff50_8080_1060,
        48'h00ff_8080_1060};

    always #5 clk = ~clk;

    gesture_detect_control #(.CYCLES_PER_MS(CPM), .DEVICE_CODE(DEV),
        .MAKER_CODE(MAK)) uut (.i_sys_clk(clk), .i_reset_n(rst_n),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_gesture_mode_enable(mode), .i_proximity_result(prox),
        .i_proximity_valid(pv), .i_north_raw(raw[31:24]),
        .i_south_raw(raw[23:16]), .i_east_raw(raw[15:8]),
        .i_west_raw(raw[7:0]), .i_dataset_valid(dv), .o_gesture_led(led),
        .o_dataset_req(req), .o_gesture_event(ev), .o_integrating(integ),
        .o_north_data(nd), .o_south_data(sd), .o_east_data(ed),
        .o_west_data(wd));

    fe_model front (.i_clk(clk), .i_req(req), .i_integ(integ), .i_dly(dly),
        .i_gate_set(gset), .i_run_set(rset), .o_valid(dv), .o_raw(raw));

    always @(posedge clk)
    begin
        cyc     <= cyc + 1;
        led_cnt <= led_cnt + led;
        ev_cnt  <= ev_cnt + ev;
        ei_cnt  <= ei_cnt + (ev & integ);
        quiet   <= (led | req | ev) ? 0 : quiet + 1;
        if (req)
        begin
            req_cnt <= req_cnt + 1;
            t1      <= t2;
            t2      <= cyc;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rvalid, 1'b1);
        check(rdata, exp);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // one proximity result, then wait for the sequencer to go quiet
    task automatic attempt(input prox_data_t p, input int er, input int ee);
        int r0, e0, l0, n;
        r0 = req_cnt;
        e0 = ev_cnt;
        l0 = led_cnt;
        n  = 0;
        @(posedge clk);
        prox <= p;
        pv   <= 1'b1;
        @(posedge clk);
        pv <= 1'b0;
        while (!(n > 10 && req_cnt - r0 >= er && integ === 1'b0
                 && quiet > 8) && n < 8000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 8000)
        begin
            error_cnt++;
            $display("Error at %0t: sequencer hang", $time);
            conclude();
        end
        check(req_cnt - r0, er);
        check(ev_cnt - e0, ee);
        leds = led_cnt - l0;
    endtask

    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            rd_chk(rows[i][31:24], rows[i][15:8]);
            wr_reg(rows[i][31:24], rows[i][23:16]);
            rd_chk(rows[i][31:24], rows[i][7:0]);
        end
        do_reset();
        rd_chk(8'h93, 8'hff);
        $display("test registers done");
        wr_reg(8'h93, 8'h00);
        wr_reg(8'hc3, 8'h00);
        wr_reg(8'h91, 8'h13);
        gset <= 32'h4040_4040;
        rset <= 32'h4040_4040;
        attempt(11'h000, 32, 1);
        check(leds, 96);
        check(t2 - t1 >= 2 * CPM + 1 && t2 - t1 <= 2 * CPM + 15, 1'b1);
        $display("test full run done");
        wr_reg(8'h91, 8'h00);
        // exit equal to entry, both above north crosstalk, below south crosstalk
        wr_reg(8'h93, 8'h50);
        wr_reg(8'h94, 8'h50);
        wr_reg(8'h92, 8'h0c);
        wr_reg(8'h95, 8'h20);
        wr_reg(8'h96, 8'h10);
        wr_reg(8'h97, 8'h90);
        gset <= 32'h8080_1060;
        rset <= 32'h2010_1010;
        dly  <= 4'h3;
        attempt(11'h051, 5, 1);
        check(leds, 5);
        check({nd, sd, ed, wd}, 32'h1000_1010);
        $display("test persistence done");
        foreach (gx[i])
        begin
            wr_reg(8'h95, gx[i][47:40]);
            wr_reg(8'h94, gx[i][39:32]);
            gset <= gx[i][31:0];
            attempt(11'h051, 1, 0);
        end
        $display("test gate done");
        wr_reg(8'h93, 8'h00);
        wr_reg(8'hc3, 8'h01);
        wr_reg(8'h94, 8'h00);
        wr_reg(8'h95, 8'h00);
        attempt(11'h100, 0, 0);
        @(posedge clk);
        mode <= 1'b0;
        attempt(11'h200, 0, 0);
        @(posedge clk);
        mode <= 1'b1;
        // longest wait code on the last full run
        wr_reg(8'h91, 8'h70);
        attempt(11'h101, 32, 1);
        check(t2 - t1 >= 22 * CPM + 1 && t2 - t1 <= 22 * CPM + 15, 1'b1);
        check(ei_cnt, ev_cnt);
        $display("test entry done");
        conclude();
    end
endmodule
`default_nettype wire
